// file: core/ssq_pin_sync.sv
// Three-stage synchroniser with agreement filter and edge pulses.
// Assumes pins are asynchronous to pclk; edges lag the pin by 3-4 cycles.
module ssq_pin_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic pclk, // Master clock
  input wire logic presetn, // Async reset, active low
  input wire logic [W-1:0] pin_in, // Raw pins
  output logic [W-1:0] level, // Filtered level
  output logic [W-1:0] rise, // One-cycle rising pulse
  output logic [W-1:0] fall // One-cycle falling pulse
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  // First stage feeds only the second, to contain metastability
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= RST_VAL;
      rise <= '0;
      fall <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2[i] == s3[i]) begin
          level[i] <= s3[i];
        end
        rise[i] <= (s2[i] == s3[i]) && s3[i] && !level[i];
        fall[i] <= (s2[i] == s3[i]) && !s3[i] && level[i];
      end
    end
  end

endmodule

// file: core/ssq_pkg.sv
// Shared constants and types for the stereo converter sequencer.
// Assumes a single master clock domain; pins are synchronised in the core.
package ssq_pkg;

  // ----------------------------------------------------------------
  // Result and timing
  // ----------------------------------------------------------------
  localparam int RES_BITS = 16;
  localparam int CONV_CYCLES = 192;
  localparam int unsigned CAL_CYCLES = 34584480;
  localparam int SEQ_W = 26;
  localparam int BITCNT_W = 5;

  // ----------------------------------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] LEFT_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] RIGHT_OFS = 8'h0c;

  // Control fields
  localparam int CTRL_TWOS_BIT = 0;
  localparam int CTRL_SLEEP_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;

  // Status fields
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_ACQ_RIGHT_BIT = 2;
  localparam int STAT_SLEEP_BIT = 3;
  localparam int STAT_CAL_BIT = 4;

  // Pin synchroniser lanes
  localparam int PIN_HOLD = 0;
  localparam int PIN_CHAN = 1;
  localparam int PIN_SCLK = 2;
  localparam int PIN_W = 3;
  localparam logic [PIN_W-1:0] PIN_RST = 3'h3;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_CAL = 4'b0001,
    ST_IDLE = 4'b0010,
    ST_CONV = 4'b0100,
    ST_SLEEP = 4'b1000
  } ssq_state_e;

endpackage

// file: core/ssq_sequencer.sv
// Conversion sequencer, serial output and APB registers of the converter.
// Assumes pclk is the master clock; hold, channel select and serial clock
// arrive on pins from the host timing generator, unsynchronised.

module ssq_sequencer import ssq_pkg::*; #(
  parameter int unsigned CAL_LEN = CAL_CYCLES
) (
  input wire logic pclk, // Master clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic hold_n, // Conversion strobe pin
  input wire logic chan_sel, // Channel select pin, high is left
  input wire logic sclk, // Serial clock pin
  input wire logic [RES_BITS-1:0] core_result, // Offset binary from core
  output logic core_acq_right, // Core tracks right input
  output logic calibration_ready_n, // Low while calibrating
  output logic dual_channel_hold_ctl, // High holds both external S/H
  output logic right_channel_hold_ctl, // High holds right external S/H
  output logic left_track_indicator, // Low while left is tracked
  output logic right_track_indicator, // Low while right is tracked
  output logic serial_result_out // Serial data, MSB first
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [RES_BITS-1:0] code_fn(
    input logic [RES_BITS-1:0] raw,
    input logic twos
  );
    code_fn = twos ? {~raw[RES_BITS-1], raw[RES_BITS-2:0]} : raw;
  endfunction

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    reg_hit = (a == CTRL_OFS) || (a == STATUS_OFS) ||
              (a == LEFT_OFS) || (a == RIGHT_OFS);
  endfunction

  localparam logic [SEQ_W-1:0] CAL_LAST = SEQ_W'(CAL_LEN - 1);
  localparam logic [SEQ_W-1:0] CONV_LAST = SEQ_W'(CONV_CYCLES - 1);

  ssq_state_e state;
  ssq_state_e next_state;
  logic [SEQ_W-1:0] seq_cnt;
  logic [PIN_W-1:0] pin_lvl;
  logic [PIN_W-1:0] pin_rise;
  logic [PIN_W-1:0] pin_fall;
  logic hold_fall;
  logic sclk_rise;
  logic sclk_fall;
  logic twos_sel;
  logic sleep_req;
  logic conv_right;
  logic [RES_BITS-1:0] last_result;
  logic [RES_BITS-1:0] left_result;
  logic [RES_BITS-1:0] right_result;
  logic [RES_BITS-1:0] shreg;
  logic [BITCNT_W-1:0] bits_left;
  logic first_rise;
  logic seq_done;
  logic apb_wr;

  // ----------------------------------------------------------------
  // Pin capture
  // ----------------------------------------------------------------
  ssq_pin_sync #(
    .W(PIN_W),
    .RST_VAL(PIN_RST)
  ) u_pins (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in({sclk, chan_sel, hold_n}),
    .level(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  assign hold_fall = pin_fall[PIN_HOLD];
  assign sclk_rise = pin_rise[PIN_SCLK];
  assign sclk_fall = pin_fall[PIN_SCLK];

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  assign seq_done = (state == ST_CAL) ? (seq_cnt == CAL_LAST)
                                      : (seq_cnt == CONV_LAST);

  always_comb begin
    next_state = state;
    unique case (state)
      ST_CAL: begin
        if (seq_done) begin
          next_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (sleep_req) begin
          next_state = ST_SLEEP;
        end else if (hold_fall) begin
          next_state = ST_CONV;
        end
      end
      ST_CONV: begin
        if (seq_done) begin
          next_state = ST_IDLE;
        end
      end
      ST_SLEEP: begin
        if (!sleep_req) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_CAL;
    endcase
  end

  // Reset abandons any activity and restarts calibration from zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_CAL;
    end else begin
      state <= next_state;
    end
  end

  // One counter serves calibration and conversion timing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_cnt <= '0;
    end else if (state != next_state) begin
      seq_cnt <= '0;
    end else if (state == ST_CAL || state == ST_CONV) begin
      seq_cnt <= seq_cnt + SEQ_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      calibration_ready_n <= 1'b0;
    end else if (state == ST_CAL && seq_done) begin
      calibration_ready_n <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Channel and sample/hold control
  // ----------------------------------------------------------------
  // Channel acquired at conversion end is the one converted next
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_right <= 1'b0;
      left_track_indicator <= 1'b1;
      right_track_indicator <= 1'b1;
      dual_channel_hold_ctl <= 1'b0;
    end else if (seq_done && state != ST_IDLE && state != ST_SLEEP) begin
      conv_right <= !pin_lvl[PIN_CHAN];
      left_track_indicator <= !pin_lvl[PIN_CHAN];
      right_track_indicator <= pin_lvl[PIN_CHAN];
      dual_channel_hold_ctl <= 1'b0;
    end else if (state == ST_IDLE && next_state == ST_CONV) begin
      left_track_indicator <= 1'b1;
      right_track_indicator <= 1'b1;
      dual_channel_hold_ctl <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      right_channel_hold_ctl <= 1'b0;
    end else if (state == ST_IDLE && next_state == ST_CONV) begin
      right_channel_hold_ctl <= !conv_right;
    end
  end

  assign core_acq_right = conv_right;

  // ----------------------------------------------------------------
  // Results
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_result <= '0;
      left_result <= '0;
      right_result <= '0;
    end else if (state == ST_CONV && seq_done) begin
      last_result <= core_result;
      if (conv_right) begin
        right_result <= core_result;
      end else begin
        left_result <= core_result;
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------
  // Previous result goes out during this conversion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shreg <= '0;
      bits_left <= '0;
      first_rise <= 1'b0;
    end else if (state == ST_IDLE && next_state == ST_CONV) begin
      shreg <= code_fn(last_result, twos_sel);
      bits_left <= BITCNT_W'(RES_BITS);
      first_rise <= 1'b0;
    end else begin
      if (sclk_rise) begin
        first_rise <= 1'b1;
      end
      if (sclk_fall && first_rise && bits_left != '0) begin
        shreg <= {shreg[RES_BITS-2:0], 1'b0};
        bits_left <= bits_left - BITCNT_W'(1);
      end
    end
  end

  assign serial_result_out = shreg[RES_BITS-1];

  // ----------------------------------------------------------------
  // APB registers
  // ----------------------------------------------------------------
  assign apb_wr = psel && penable && pwrite;
  // Read data is registered in setup, so every access has no wait
  assign pready = 1'b1;
  assign pslverr = psel && penable && !reg_hit(paddr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {sleep_req, twos_sel} <= CTRL_RST;
    end else if (apb_wr && paddr == CTRL_OFS) begin
      twos_sel <= pwdata[CTRL_TWOS_BIT];
      sleep_req <= pwdata[CTRL_SLEEP_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable) begin
      prdata <= '0;
      unique case (paddr)
        CTRL_OFS: begin
          prdata[CTRL_TWOS_BIT] <= twos_sel;
          prdata[CTRL_SLEEP_BIT] <= sleep_req;
        end
        STATUS_OFS: begin
          prdata[STAT_READY_BIT] <= calibration_ready_n;
          prdata[STAT_BUSY_BIT] <= (state == ST_CONV);
          prdata[STAT_ACQ_RIGHT_BIT] <= conv_right;
          prdata[STAT_SLEEP_BIT] <= (state == ST_SLEEP);
          prdata[STAT_CAL_BIT] <= (state == ST_CAL);
        end
        LEFT_OFS: prdata[RES_BITS-1:0] <= left_result;
        RIGHT_OFS: prdata[RES_BITS-1:0] <= right_result;
        default: prdata <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [SEQ_W-1:0] since_rst;
  logic [SEQ_W-1:0] conv_len;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_rst <= '0;
      conv_len <= '0;
    end else begin
      if (since_rst != '1) begin
        since_rst <= since_rst + SEQ_W'(1);
      end
      conv_len <= (state == ST_CONV) ? conv_len + SEQ_W'(1) : '0;
    end
  end

  cal_length_a: assert property (
    $rose(calibration_ready_n) |-> since_rst == SEQ_W'(CAL_LEN))
    else $error("calibration length wrong");
  ready_low_a: assert property (
    (state == ST_CAL) |-> !calibration_ready_n)
    else $error("ready high during calibration");
  conv_start_a: assert property (
    (state == ST_IDLE && hold_fall && !sleep_req) |=> state == ST_CONV)
    else $error("strobe did not start conversion");
  conv_length_a: assert property (
    $fell(state == ST_CONV) |-> conv_len == SEQ_W'(CONV_CYCLES))
    else $error("conversion length wrong");
  track_end_a: assert property (
    $fell(state == ST_CONV) |->
      (left_track_indicator == conv_right) &&
      (right_track_indicator == !conv_right))
    else $error("track indicator wrong at conversion end");
  msb_load_a: assert property (
    $rose(state == ST_CONV) |->
      shreg == code_fn(last_result, twos_sel) && bits_left == 5'h10)
    else $error("serial word not loaded");
  shift_fall_a: assert property (
    (sclk_fall && first_rise && bits_left != '0 &&
     !(state == ST_IDLE && next_state == ST_CONV)) |=>
      serial_result_out == $past(shreg[RES_BITS-2]))
    else $error("serial bit not advanced on falling clock");
  right_hold_a: assert property (
    $rose(state == ST_CONV) |-> right_channel_hold_ctl == !conv_right)
    else $error("right hold control wrong");
  sleep_idle_a: assert property (
    (state == ST_SLEEP && !sleep_req) |=> state == ST_IDLE)
    else $error("sleep exit not immediate");

  cal_done_c: cover property ($rose(calibration_ready_n));
  left_conv_c: cover property ($fell(state == ST_CONV) && !conv_right);
  right_conv_c: cover property ($fell(state == ST_CONV) && conv_right);
  sleep_c: cover property (state == ST_SLEEP);

endmodule

// file: dv/ssq_host_model.sv
// Host timing generator model: strobe, channel select and serial clock.
// Assumes the bench calls frame() just after a rising pclk edge.
module ssq_host_model (
  input wire logic pclk, // Master clock
  input wire logic serial_result_out, // Serial data from the block
  output logic hold_n, // Conversion strobe, active low
  output logic chan_sel, // Channel select, high is left
  output logic sclk, // Serial clock, still between frames
  output logic [15:0] rx_word // Last word shifted in
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    hold_n = 1'b1;
    chan_sel = 1'b1;
    sclk = 1'b0;
    rx_word = 16'h0000;
  end

  // ----------------------------------------------------------------
  // One strobe period of 256 master clocks
  // ----------------------------------------------------------------
  task automatic frame(input logic left);
    // Select settles two clocks ahead of the strobe edge
    chan_sel <= left;
    repeat (2) @(posedge pclk);
    hold_n <= 1'b0;
    repeat (4) @(posedge pclk);
    hold_n <= 1'b1;
    repeat (4) @(posedge pclk);
    // Divide by 8 only after the first bit has settled
    for (int i = 15; i >= 0; i--) begin
      sclk <= 1'b1;
      repeat (4) @(posedge pclk);
      rx_word[i] <= serial_result_out;
      sclk <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    repeat (118) @(posedge pclk);
  endtask
endmodule

// file: dv/testbench.sv
// Self-checking bench for the converter sequencer.
// Assumes a shortened calibration and the host model on the pins.
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module testbench;
  import ssq_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CAL = 50;

  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, hold_n, chan_sel, sclk;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [RES_BITS-1:0] core_result = '0;
  logic [15:0] rx_word;
  logic core_acq_right, calibration_ready_n, dual_channel_hold_ctl;
  logic right_channel_hold_ctl, left_track_indicator;
  logic right_track_indicator, serial_result_out;
  int errors = 0, samples_checked = 0;

  always #12.5 pclk = ~pclk;

  ssq_sequencer #(.CAL_LEN(CAL)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hold_n(hold_n), .chan_sel(chan_sel), .sclk(sclk),
    .core_result(core_result), .core_acq_right(core_acq_right),
    .calibration_ready_n(calibration_ready_n),
    .dual_channel_hold_ctl(dual_channel_hold_ctl),
    .right_channel_hold_ctl(right_channel_hold_ctl),
    .left_track_indicator(left_track_indicator),
    .right_track_indicator(right_track_indicator),
    .serial_result_out(serial_result_out));

  ssq_host_model host (.pclk(pclk), .serial_result_out(serial_result_out),
    .hold_n(hold_n), .chan_sel(chan_sel), .sclk(sclk), .rx_word(rx_word));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      errors++;
      wrap_up();
    end
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] d,
                        input logic er, input string nm);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK(nm, d, r);
    `CHK("slave error", er, e);
  endtask

  // Releases reset and counts edges until ready rises
  task automatic do_cal();
    int n;
    presetn <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (calibration_ready_n !== 1'b1 && n < CAL + 20);
    `CHK("calibration length", CAL + 1, n);
    if (n >= CAL + 20)
      wrap_up();
  endtask

  // One strobe period; nl is the channel to acquire at its end
  task automatic conv(input logic nl, input logic rh);
    int d, m;
    d = 0;
    m = 0;
    fork
      host.frame(nl);
      begin
        while (hold_n !== 1'b0 && d < 8) begin
          @(posedge pclk);
          d++;
        end
        d = 0;
        while (dual_channel_hold_ctl !== 1'b1 && d < 20) begin
          @(posedge pclk);
          d++;
        end
        `CHK("start delay ok", 1, d >= 3 && d <= 6);
        `CHK("right hold", rh, right_channel_hold_ctl);
        `CHK("tracks busy", 2'b11,
             {left_track_indicator, right_track_indicator});
        while (dual_channel_hold_ctl === 1'b1 && m < 300) begin
          m++;
          @(posedge pclk);
        end
        `CHK("conversion length", CONV_CYCLES, m);
        `CHK("tracks idle", nl ? 2'b01 : 2'b10,
             {left_track_indicator, right_track_indicator});
        `CHK("acquire right", !nl, core_acq_right);
        `CHK("right hold kept", rh, right_channel_hold_ctl);
      end
    join
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic sc_regs();
    rd_chk(CTRL_OFS, 32'h0, 1'b0, "ctrl reset");
    rd_chk(STATUS_OFS, 32'h1, 1'b0, "status ready");
    wr(STATUS_OFS, 32'hff);
    rd_chk(STATUS_OFS, 32'h1, 1'b0, "status read only");
    rd_chk(8'h10, 32'h0, 1'b1, "unmapped read");
  endtask

  // Three conversions L, R, L; each frame carries the previous result
  task automatic sc_stream();
    core_result <= 16'ha5c3;
    conv(1'b0, 1'b1);
    `CHK("first word", 16'h0000, rx_word);
    rd_chk(LEFT_OFS, 32'ha5c3, 1'b0, "left result");
    core_result <= 16'h1234;
    conv(1'b1, 1'b0);
    `CHK("serial word", 16'ha5c3, rx_word);
    rd_chk(RIGHT_OFS, 32'h1234, 1'b0, "right result");
    wr(CTRL_OFS, 32'h1);
    core_result <= 16'h00ff;
    conv(1'b0, 1'b1);
    `CHK("twos word", 16'h9234, rx_word);
    wr(CTRL_OFS, 32'h0);
  endtask

  task automatic sc_sleep();
    logic seen;
    seen = 1'b0;
    wr(CTRL_OFS, 32'h2);
    rd_chk(STATUS_OFS, 32'hd, 1'b0, "status asleep");
    fork
      host.frame(1'b1);
      repeat (250) begin
        @(posedge pclk);
        seen = seen | dual_channel_hold_ctl;
      end
    join
    `CHK("strobe while asleep", 1'b0, seen);
    wr(CTRL_OFS, 32'h0);
    conv(1'b1, 1'b0);
    `CHK("ready kept", 1'b1, calibration_ready_n);
    `CHK("offset word", 16'h00ff, rx_word);
  endtask

  task automatic sc_reset_mid();
    fork
      host.frame(1'b1);
      begin
        repeat (60) @(posedge pclk);
        `CHK("converting", 1'b1, dual_channel_hold_ctl);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        `CHK("abandoned", 1'b0, dual_channel_hold_ctl);
        `CHK("ready dropped", 1'b0, calibration_ready_n);
        do_cal();
      end
    join
    rd_chk(STATUS_OFS, 32'h1, 1'b0, "status recal");
  endtask

  initial begin
    // Power-up reset before anything else
    repeat (10) @(posedge pclk);
    do_cal();
    sc_regs();
    sc_stream();
    sc_sleep();
    sc_reset_mid();
    wrap_up();
  end
endmodule
